//--- design/hpa_defines.vh
// Constants for the hot-plug event aggregator
// Summary of operation
// R1: Four slot interrupt-pending bits, masked per slot
// R2: Five irq-capable slot flags, each own mask
// R3: Command-done pending when flag set, mask clear
// R4: Four slot system-error pending bits, masked
// R5: Only latch change, connected fault raise syserr
// R6: Arbiter pending when timeout flag, mask clear
// R7: Wake from slot pending or command done
// R8: Interrupt is wake gated by global mask
// R9: Syserr from slots or arbiter, global mask
// R10: Timeout after 2^23 ungranted request cycles
// R11: Timeout flag bit 17, write one clears
// R12: Command-done flag bit 16 on busy fall
// R13: Global interrupt mask bit 0
// R14: Global syserr mask bit 1
// R15: Command-done interrupt mask bit 2
// R16: Arbiter syserr mask bit 3
// R17: Slot mask one blocks its flag
// R18: Timeout counter restarts on grant or withdraw
// R19: Outputs follow current flags and masks; o_irq instead comes from sticky evt_sts and holds until cleared
`ifndef HPA_DEFINES_VH
`define HPA_DEFINES_VH
`define HPA_OFS_IRQ_LOC      8'h18
`define HPA_OFS_SERR_LOC     8'h1c
`define HPA_OFS_CTRL         8'h20
`define HPA_OFS_EVT_STS      8'h40
`define HPA_OFS_EVT_MASK     8'h44
`define HPA_CTRL_RESET       32'h0000_000f
`define HPA_BIT_GLB_IRQ_M    0
`define HPA_BIT_GLB_SERR_M   1
`define HPA_BIT_CMD_IRQ_M    2
`define HPA_BIT_ARB_SERRM    3
`define HPA_BIT_CC_FLAG      16
`define HPA_BIT_ARB_FLAG     17
`define HPA_ARB_TIMEOUT_CYC  8388608
`endif

//--- design/hpa_arb_timer.v
// Arbiter wait timer for hot-plug bus requests
`timescale 1ns/1ps
module hpa_arb_timer #(
    parameter CYCLES = 8388608,
    parameter W      = 24
) (
    // Clock and reset
    input  wire i_ref_clk,
    input  wire i_rst,
    // Request and grant
    input  wire i_req,
    input  wire i_gnt,
    // One-cycle timeout pulse
    output reg  o_timeout
);
    reg [W-1:0] count;  // Ungranted wait length
    // Last count value before the timeout pulse
    localparam [W-1:0] LAST = CYCLES - 1;
    // Count continuous ungranted request cycles
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            count     <= {W{1'b0}};
            o_timeout <= 1'b0;
        end else if (!i_req || i_gnt) begin
            count     <= {W{1'b0}}; // R18
            o_timeout <= 1'b0;
        end else if (count == LAST) begin
            count     <= {W{1'b0}};
            o_timeout <= 1'b1; // R10
        end else begin
            count     <= count + 1'b1;
            o_timeout <= 1'b0;
        end
    end
endmodule

//--- design/hpa_slot_combine.v
// Per-slot pending decode for one slot
`timescale 1ns/1ps
module hpa_slot_combine (
    // Slot status flags
    input  wire [4:0] i_flags,
    // Interrupt masks, same order
    input  wire [4:0] i_irq_mask,
    // Syserr masks: latch, connected fault
    input  wire [1:0] i_serr_mask,
    // Pending outputs
    output wire       o_irq_pend,
    output wire       o_serr_pend
);
    // Order: presence, isolated fault, button, latch, connected fault
    assign o_irq_pend  = |(i_flags & ~i_irq_mask); // R1 R2 R17
    assign o_serr_pend = |(i_flags[4:3] & ~i_serr_mask); // R4 R5
endmodule

//--- design/hpa_top.v
// Hot-plug event aggregator top with register slave
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "hpa_defines.vh"
module hpa_top #(
    parameter NSLOT       = 4,
    parameter ARB_CYCLES  = `HPA_ARB_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire              i_ref_clk,
    input  wire              i_rst,
    // Register port
    input  wire [7:0]        i_addr,
    input  wire [31:0]       i_wdata,
    input  wire              i_wr,
    input  wire              i_rd,
    output reg  [31:0]       o_rdata,
    // Per-slot flags and interrupt masks five bits per slot, syserr masks two bits per slot
    input  wire [NSLOT*5-1:0] i_slot_flags,
    input  wire [NSLOT*5-1:0] i_slot_irq_mask,
    input  wire [NSLOT*2-1:0] i_slot_serr_mask,
    // Controller busy and arbiter handshake
    input  wire              i_controller_busy_flag,
    input  wire              i_arb_req,
    input  wire              i_arb_gnt,
    // Event outputs
    output wire              o_hotplug_wake,
    output wire              o_hotplug_irq,
    output wire              o_hotplug_syserr,
    output wire              o_bridge_irq_a_pin_n,
    output wire              o_power_event_flag,
    output wire              o_received_syserr_flag,
    // Block interrupt
    output wire              o_irq
);
    // Control register mask bits
    reg              global_irq_mask;
    reg              global_syserr_mask;
    reg              cmd_done_irq_mask;
    reg              arb_syserr_mask;
    // Sticky flags
    reg              arb_timeout_flag;
    reg              cmd_done_flag;
    reg              busy_d;       // Busy of last cycle
    // Block event status and mask
    reg  [1:0]       evt_sts;
    reg  [1:0]       evt_mask;
    wire             arb_to;       // Timeout pulse
    wire [NSLOT-1:0] slot_irq_pending;
    wire [NSLOT-1:0] slot_syserr_pending;
    wire             cmd_done_irq_pending;
    wire             arb_syserr_pending;
    wire             wr_ctrl;
    wire             wr_evt;
    wire             cc_rise;

    // One decoder per slot
    genvar g;
    generate
        for (g = 0; g < NSLOT; g = g + 1) begin : g_slot
            hpa_slot_combine u_slot (
                .i_flags     (i_slot_flags[g*5 +: 5]),
                .i_irq_mask  (i_slot_irq_mask[g*5 +: 5]),
                .i_serr_mask (i_slot_serr_mask[g*2 +: 2]),
                .o_irq_pend  (slot_irq_pending[g]),
                .o_serr_pend (slot_syserr_pending[g])
            );
        end
    endgenerate

    // Arbiter wait timer
    hpa_arb_timer #(
        .CYCLES (ARB_CYCLES),
        .W      (24)
    ) u_timer (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_req     (i_arb_req),
        .i_gnt     (i_arb_gnt),
        .o_timeout (arb_to)
    );

    // Pending terms, purely combinational
    assign cmd_done_irq_pending = cmd_done_flag & ~cmd_done_irq_mask; // R3 R15
    assign arb_syserr_pending   = arb_timeout_flag & ~arb_syserr_mask; // R6 R16
    assign o_hotplug_wake   = (|slot_irq_pending) | cmd_done_irq_pending; // R7 R19
    assign o_hotplug_irq    = ~global_irq_mask & o_hotplug_wake; // R8 R13
    assign o_hotplug_syserr = ~global_syserr_mask &
                              ((|slot_syserr_pending) | arb_syserr_pending); // R9 R14
    assign o_bridge_irq_a_pin_n   = ~o_hotplug_irq; // R8
    assign o_power_event_flag     = o_hotplug_wake; // R7
    assign o_received_syserr_flag = o_hotplug_syserr; // R9

    // Write decodes
    assign wr_ctrl = i_wr && (i_addr == `HPA_OFS_CTRL);
    assign wr_evt  = i_wr && (i_addr == `HPA_OFS_EVT_STS);
    assign cc_rise = busy_d & ~i_controller_busy_flag;

    // Control register and sticky flags; set wins over clear
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            global_irq_mask    <= 1'b1;
            global_syserr_mask <= 1'b1;
            cmd_done_irq_mask  <= 1'b1;
            arb_syserr_mask    <= 1'b1;
            arb_timeout_flag   <= 1'b0;
            cmd_done_flag      <= 1'b0;
            busy_d             <= 1'b0;
        end else begin
            busy_d <= i_controller_busy_flag;
            if (wr_ctrl) begin
                global_irq_mask    <= i_wdata[`HPA_BIT_GLB_IRQ_M];
                global_syserr_mask <= i_wdata[`HPA_BIT_GLB_SERR_M];
                cmd_done_irq_mask  <= i_wdata[`HPA_BIT_CMD_IRQ_M];
                arb_syserr_mask    <= i_wdata[`HPA_BIT_ARB_SERRM];
            end
            // Timeout flag
            if (arb_to)
                arb_timeout_flag <= 1'b1; // R11
            else if (wr_ctrl && i_wdata[`HPA_BIT_ARB_FLAG])
                arb_timeout_flag <= 1'b0; // R11
            // Command-done flag
            if (cc_rise)
                cmd_done_flag <= 1'b1; // R12
            else if (wr_ctrl && i_wdata[`HPA_BIT_CC_FLAG])
                cmd_done_flag <= 1'b0; // R12
        end
    end

    // Block event status: bit0 interrupt, bit1 syserr
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            evt_sts  <= 2'b00;
            evt_mask <= 2'b11;
        end else begin
            evt_sts <= (evt_sts & ~({2{wr_evt}} & i_wdata[1:0]))
                       | {o_hotplug_syserr, o_hotplug_irq};
            if (i_wr && (i_addr == `HPA_OFS_EVT_MASK))
                evt_mask <= i_wdata[1:0];
        end
    end
    assign o_irq = |(evt_sts & ~evt_mask);

    // Read data one cycle after strobe
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            case (i_addr)
                `HPA_OFS_IRQ_LOC:  o_rdata <= {27'd0, slot_irq_pending, cmd_done_irq_pending};
                `HPA_OFS_SERR_LOC: o_rdata <= {27'd0, slot_syserr_pending, arb_syserr_pending};
                `HPA_OFS_CTRL:     o_rdata <= {14'd0, arb_timeout_flag, cmd_done_flag, 12'd0,
                                               arb_syserr_mask, cmd_done_irq_mask,
                                               global_syserr_mask, global_irq_mask};
                `HPA_OFS_EVT_STS:  o_rdata <= {30'd0, evt_sts};
                `HPA_OFS_EVT_MASK: o_rdata <= {30'd0, evt_mask};
                default:           o_rdata <= 32'h0000_0000;
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end
endmodule

//--- testbench/hpa_host_model.sv
// Host side model: records interrupt pin and system error reports
`timescale 1ns/1ps
module hpa_host_model (
    input  wire  i_ref_clk,
    input  wire  i_rst,
    input  wire  i_pin_n,
    input  wire  i_syserr,
    output logic o_irq_seen,
    output logic o_serr_seen
);
    // Sticky capture of what the bridge reports
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_irq_seen  <= 1'h0;
            o_serr_seen <= 1'h0;
        end else begin
            if (!i_pin_n) o_irq_seen <= 1'h1;
            if (i_syserr) o_serr_seen <= 1'h1;
        end
    end
endmodule

//--- testbench/hpa_monitor.sv
// Port checker for the hot-plug event aggregator
`timescale 1ns/1ps
module hpa_monitor #(parameter NSLOT = 4) (
    input wire              i_ref_clk, i_rst, i_rd,
    input wire [7:0]        i_addr,
    input wire [31:0]       o_rdata,
    input wire [NSLOT*5-1:0] i_slot_flags, i_slot_irq_mask,
    input wire [NSLOT*2-1:0] i_slot_serr_mask,
    input wire              o_hotplug_wake, o_hotplug_irq, o_hotplug_syserr,
    input wire              o_bridge_irq_a_pin_n, o_power_event_flag, o_received_syserr_flag
);
    logic [3:0] ip; // Expected slot interrupt pending
    logic [3:0] sp; // Expected slot syserr pending
    // Per-slot pending worked out from flags and masks
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            ip[n] = |(i_slot_flags[5*n+:5] & ~i_slot_irq_mask[5*n+:5]);
            sp[n] = |(i_slot_flags[5*n+3+:2] & ~i_slot_serr_mask[2*n+:2]);
        end
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    a_pin_inverse: assert property (o_bridge_irq_a_pin_n == !o_hotplug_irq) else $error("pin level wrong");
    a_irq_wake: assert property (o_hotplug_irq |-> o_hotplug_wake) else $error("irq without wake");
    a_slot_wake: assert property (|ip |-> o_hotplug_wake) else $error("slot pending without wake");
    a_pme_wake: assert property (o_power_event_flag == o_hotplug_wake) else $error("pme differs");
    a_rcv_serr: assert property (o_received_syserr_flag == o_hotplug_syserr) else $error("rcv flag differs");
    a_irq_loc: assert property (i_rd && i_addr == 8'h18 |=> o_rdata[31:1] == {27'h0, $past(ip)})
        else $error("irq locator wrong");
    a_serr_loc: assert property (i_rd && i_addr == 8'h1c |=> o_rdata[31:1] == {27'h0, $past(sp)})
        else $error("syserr locator wrong");
    a_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0) else $error("read data not idle");
endmodule
bind hpa_top hpa_monitor #(.NSLOT(NSLOT)) u_mon (.*);

//--- testbench/hpa_top_tb.sv
// Self-checking bench for the hot-plug event aggregator
`timescale 1ns/1ps
module hpa_top_tb;
    logic i_ref_clk, i_rst = 1, i_wr = 0, i_rd = 0, i_controller_busy_flag = 0, i_arb_req = 0, i_arb_gnt = 0;
    logic [7:0] i_addr = 0, i_slot_serr_mask = 0;
    logic [31:0] i_wdata = 0, o_rdata;
    logic [19:0] i_slot_flags = 0, i_slot_irq_mask = 0;
    wire o_hotplug_wake, o_hotplug_irq, o_hotplug_syserr, o_bridge_irq_a_pin_n;
    wire o_power_event_flag, o_received_syserr_flag, o_irq, irq_seen, serr_seen;
    int bad_count = 0, cmp_count = 0, cyc = 0;
    hpa_top #(.ARB_CYCLES(16)) dut (.*);
    hpa_host_model host (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_pin_n(o_bridge_irq_a_pin_n),
        .i_syserr(o_hotplug_syserr), .o_irq_seen(irq_seen), .o_serr_seen(serr_seen));
    initial begin
        i_ref_clk = 0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge i_ref_clk); i_addr <= a; i_wdata <= d; i_wr <= 1'h1;
        @(posedge i_ref_clk); i_wr <= 1'h0; #1;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e, string n);
        @(posedge i_ref_clk); i_addr <= a; i_rd <= 1'h1;
        @(posedge i_ref_clk); i_rd <= 1'h0; #1 chk(n, e, o_rdata);
    endtask
    task t_reset;
        rd(8'h20, 32'hf, "ctrl_rst");
        wr(8'h18, 32'hffff_ffff); rd(8'h18, 0, "irq_loc_ro");
        rd(8'h1c, 0, "serr_loc_rst"); rd(8'h00, 0, "unmapped");
        $display("t_reset done");
    endtask
    task t_slot;
        wr(8'h20, 0);
        for (int k = 0; k < 40; k++) begin
            @(posedge i_ref_clk); i_slot_flags <= 20'h1 << (k/2);
            i_slot_irq_mask <= (k%2) ? 20'hf_ffff : 20'h0; i_slot_serr_mask <= (k%2) ? 8'hff : 8'h0;
            rd(8'h18, (k%2) ? 0 : 32'h2 << (k/10), "irq_loc");
            rd(8'h1c, (k%2 || (k/2)%5 < 3) ? 0 : 32'h2 << (k/10), "serr_loc");
            chk("wake", !(k%2), o_hotplug_wake);
            chk("pin_n", k%2, o_bridge_irq_a_pin_n);
            chk("syserr", !(k%2) && (k/2)%5 > 2, o_hotplug_syserr);
        end
        @(posedge i_ref_clk); i_slot_flags <= 0;
        chk("host_irq", 1, irq_seen);
        $display("t_slot done");
    endtask
    task t_cmd;
        @(posedge i_ref_clk); i_controller_busy_flag <= 1'h1;
        @(posedge i_ref_clk); i_controller_busy_flag <= 1'h0;
        repeat (2) @(posedge i_ref_clk);
        rd(8'h18, 1, "cc_pend"); chk("cc_irq", 1, o_hotplug_irq);
        wr(8'h20, 1); chk("glb_irq_mask", 0, o_hotplug_irq); rd(8'h20, 32'h1_0001, "cc_kept");
        wr(8'h20, 4); rd(8'h18, 0, "cc_mask");
        wr(8'h20, 32'h1_0000); rd(8'h20, 0, "cc_clr");
        $display("t_cmd done");
    endtask
    task t_arb;
        @(posedge i_ref_clk); i_arb_req <= 1'h1;
        repeat (10) @(posedge i_ref_clk); i_arb_gnt <= 1'h1;
        @(posedge i_ref_clk); i_arb_gnt <= 1'h0;
        repeat (10) @(posedge i_ref_clk); i_arb_req <= 1'h0;
        @(posedge i_ref_clk); i_arb_req <= 1'h1;
        repeat (10) @(posedge i_ref_clk); i_arb_req <= 1'h0;
        rd(8'h20, 0, "no_tout");
        @(posedge i_ref_clk); i_arb_req <= 1'h1;
        repeat (20) @(posedge i_ref_clk); i_arb_req <= 1'h0;
        rd(8'h20, 32'h2_0000, "tout"); rd(8'h1c, 1, "arb_pend");
        chk("arb_serr", 1, o_hotplug_syserr); chk("host_serr", 1, serr_seen);
        wr(8'h20, 2); chk("glb_serr_mask", 0, o_hotplug_syserr); rd(8'h20, 32'h2_0002, "tout_kept");
        wr(8'h20, 8); rd(8'h1c, 0, "arb_mask");
        wr(8'h20, 32'h2_0000); rd(8'h20, 0, "tout_clr");
        $display("t_arb done");
    endtask
    task t_evt;
        rd(8'h44, 3, "evt_mask_rst"); chk("irq_masked", 0, o_irq);
        wr(8'h40, 3); wr(8'h44, 0); chk("irq_idle", 0, o_irq);
        @(posedge i_ref_clk); i_slot_flags <= 20'h1; i_slot_irq_mask <= 20'h0;
        repeat (2) @(posedge i_ref_clk); #1 chk("irq_on", 1, o_irq);
        wr(8'h44, 3); chk("irq_mask", 0, o_irq);
        @(posedge i_ref_clk); i_slot_flags <= 0;
        wr(8'h40, 3); rd(8'h40, 0, "evt_clr");
        wr(8'h44, 0); chk("irq_off", 0, o_irq);
        $display("t_evt done");
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            wrap_up;
        end
    end
    initial begin
        repeat (4) @(posedge i_ref_clk);
        i_rst <= 1'h0;
        t_reset; t_slot; t_cmd; t_arb; t_evt;
        wrap_up;
    end
endmodule
